/* File: cevn_notifier.sv */
// Top of the camera event notifier: detection, per-source enables, queue and sender.
`timescale 1ns/10ps
`default_nettype none

module cevn_notifier
   import cevn_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   // Host-side settings.
   input  wire logic [SRC_W-1:0] event_source_select,
   input  wire logic             event_send_enable_wr,
   input  wire logic [1:0]       event_send_enable_wdata,
   input  wire logic             line_edge_activation_wr,
   input  wire logic [1:0]       line_edge_activation_wdata,
   output logic      [1:0]       event_send_enable,
   output logic      [1:0]       line_edge_activation,
   // Camera-side event sources.
   input  wire cevn_strobe_t     strobe,
   input  wire logic [3:0]       io_level,
   input  wire logic [3:0]       io_is_output,
   // Control-channel message port.
   output logic                  msg_valid,
   output logic      [SRC_W-1:0] msg_src,
   output logic                  msg_legacy,
   input  wire logic             msg_ready,
   output logic                  message_queue_overflow_evt
);

   typedef struct packed {
      logic [NUM_SRC-1:0][1:0] en;
      logic [NUM_SRC-1:0][1:0] act;
      logic [3:0]              io_prev;
      logic                    io_primed;
      logic [NUM_SRC-1:0]      pend;
      logic                    ovf_pend;
      logic                    msg_valid;
      cevn_msg_t               msg;
      logic                    ovf_evt;
      logic [1:0]              rd_en;
      logic [1:0]              rd_act;
   } cevn_state_t;

   cevn_state_t        st;
   cevn_state_t        next_st;
   logic [NUM_SRC-1:0] raw;
   logic [NUM_SRC-1:0] gated;
   cevn_msg_t          q_wr_data;
   logic               q_wr;
   logic               q_rd;
   cevn_msg_t          q_rd_data;
   logic               q_empty;
   logic               q_full;
   logic [SRC_W-1:0]   pick;
   logic               pick_any;
   logic               overflow;

   cevn_queue cevn_queue_inst (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .wr_en   (q_wr),
      .wr_data (q_wr_data),
      .rd_en   (q_rd),
      .rd_data (q_rd_data),
      .empty   (q_empty),
      .full    (q_full)
   );

   always_comb begin
      raw = '0;
      raw[SRC_ACQ_BEGIN]      = strobe.acq_begin;
      raw[SRC_ACQ_FINISH]     = strobe.acq_finish;
      raw[SRC_FRAME_BEGIN]    = strobe.frame_begin;
      raw[SRC_FRAME_FINISH]   = strobe.frame_finish;
      raw[SRC_FTRIG_ACCEPT]   = strobe.frame_trig_accepted;
      raw[SRC_FTRIG_REJECT]   = strobe.frame_trig_rejected;
      raw[SRC_IMAGE_DROP]     = strobe.image_dropped;
      raw[SRC_LTRIG_REJECT]   = strobe.line_trig_rejected;
      raw[SRC_LTRIG_POSTPONE] = strobe.line_trig_postponed;
      for (int i = 0; i < 4; i++) begin
         // A line driven as an output ignores activation and its own level changes.
         if (st.io_primed && !io_is_output[i]) begin
            case (st.act[int'(SRC_IO1_CHANGE) + i])
               EDGE_RISE:   raw[int'(SRC_IO1_CHANGE) + i] = io_level[i] && !st.io_prev[i];
               EDGE_FALL:   raw[int'(SRC_IO1_CHANGE) + i] = !io_level[i] && st.io_prev[i];
               default:     raw[int'(SRC_IO1_CHANGE) + i] = io_level[i] != st.io_prev[i];
            endcase
         end
         raw[int'(SRC_IO3_PULSE) + i] = strobe.io_pulse[i];
      end
      for (int i = 0; i < NUM_SRC; i++) begin
         gated[i] = raw[i] && (st.en[i] != SEND_OFF);
      end
   end

   // Lowest pending source goes to the queue first; one write per cycle.
   always_comb begin
      pick     = '0;
      pick_any = 1'b0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (st.pend[i]) begin
            pick     = SRC_W'(i);
            pick_any = 1'b1;
         end
      end
   end

   // A new occurrence of a source still waiting for a queue slot means the
   // path cannot keep up, which counts as an overflow as well as a full queue.
   assign overflow  = |(gated & st.pend) || (pick_any && q_full);
   assign q_wr      = (st.ovf_pend || pick_any) && !q_full;
   // The overflow report goes ahead of any pending source, so the host hears of the loss first.
   always_comb begin
      q_wr_data.src    = pick;
      q_wr_data.legacy = (st.en[pick] == SEND_LEGACY);
      if (st.ovf_pend) begin
         q_wr_data.src    = SRC_OVERFLOW;
         q_wr_data.legacy = 1'b0;
      end
   end
   assign q_rd      = !q_empty && (!st.msg_valid || msg_ready);

   always_comb begin
      next_st         = st;
      next_st.ovf_evt = 1'b0;
      next_st.io_prev   = io_level;
      next_st.io_primed = 1'b1;
      if (event_send_enable_wr) begin
         next_st.en[event_source_select] = event_send_enable_wdata;
      end
      if (line_edge_activation_wr) begin
         next_st.act[event_source_select] = line_edge_activation_wdata;
      end
      next_st.rd_en  = next_st.en[event_source_select];
      next_st.rd_act = next_st.act[event_source_select];
      if (q_wr && !st.ovf_pend) begin
         next_st.pend[pick] = 1'b0;
      end
      if (q_wr && st.ovf_pend) begin
         next_st.ovf_pend = 1'b0;
      end
      next_st.pend = next_st.pend | gated;
      if (overflow) begin
         // Enables stay off until the host writes them again.
         for (int i = 0; i < NUM_SRC; i++) begin
            next_st.en[i] = SEND_OFF;
         end
         next_st.pend     = '0;
         next_st.ovf_pend = 1'b1;
         next_st.ovf_evt  = 1'b1;
         next_st.rd_en    = SEND_OFF;
      end
      if (st.msg_valid && msg_ready) begin
         next_st.msg_valid = 1'b0;
      end
      if (q_rd) begin
         next_st.msg_valid = 1'b1;
         next_st.msg       = q_rd_data;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign event_send_enable          = st.rd_en;
   assign line_edge_activation       = st.rd_act;
   assign msg_valid                  = st.msg_valid;
   assign msg_src                    = st.msg.src;
   assign msg_legacy                 = st.msg.legacy;
   assign message_queue_overflow_evt = st.ovf_evt;

endmodule

`default_nettype wire

/* File: cevn_pkg.sv */
// Package of constants and types for the camera event notifier.
// What this block does
// - A selector port picks which event source the enable setting reads and writes.
// - Enable set to Off drops every occurrence of that event, no message.
// - Enable set to On sends one message per occurrence of that event.
// - A legacy-compatible enabled value sends messages flagged in the legacy format.
// - Input line events fire on rising, falling or either edge per activation setting.
// - Edge activation applies to input lines only; output lines fire on pulse start.
// - Four line state-change sources exist, one each for lines 1 to 4.
// - Four pulse-start sources exist, one each for lines 3 to 6.
// - On message queue overflow all events are disabled and an overflow event sent.
// - Frame start fires when exposure delay of the frame's first line begins.
// - Frame end fires when an active frame completes.
// - An accepted valid frame trigger raises its own event.
// - A frame trigger rejected in an invalid region raises its own event.
// - A line trigger rejected in an invalid region raises its own event.
// - A line trigger postponed into a valid region raises an overlap event.
// - An image dropped for lack of buffer memory raises its own event.
// - Acquisition start and acquisition end each raise their own event.
package cevn_pkg;

   localparam int NUM_SRC   = 18;
   localparam int SRC_W     = 5;
   localparam int QDEPTH    = 8;
   localparam int QPTR_W    = 3;
   localparam int QCNT_W    = 4;

   // Event source codes, also the selector values and the message identifiers.
   localparam logic [SRC_W-1:0] SRC_ACQ_BEGIN      = 5'h00;
   localparam logic [SRC_W-1:0] SRC_ACQ_FINISH     = 5'h01;
   localparam logic [SRC_W-1:0] SRC_FRAME_BEGIN    = 5'h02;
   localparam logic [SRC_W-1:0] SRC_FRAME_FINISH   = 5'h03;
   localparam logic [SRC_W-1:0] SRC_FTRIG_ACCEPT   = 5'h04;
   localparam logic [SRC_W-1:0] SRC_FTRIG_REJECT   = 5'h05;
   localparam logic [SRC_W-1:0] SRC_IMAGE_DROP     = 5'h06;
   localparam logic [SRC_W-1:0] SRC_LTRIG_REJECT   = 5'h07;
   localparam logic [SRC_W-1:0] SRC_LTRIG_POSTPONE = 5'h08;
   localparam logic [SRC_W-1:0] SRC_IO1_CHANGE     = 5'h09;
   localparam logic [SRC_W-1:0] SRC_IO3_PULSE      = 5'h0d;
   localparam logic [SRC_W-1:0] SRC_OVERFLOW       = 5'h11;

   // Enable setting encodings.
   localparam logic [1:0] SEND_OFF    = 2'h0;
   localparam logic [1:0] SEND_ON     = 2'h1;
   localparam logic [1:0] SEND_LEGACY = 2'h2;

   // Edge activation encodings.
   localparam logic [1:0] EDGE_RISE   = 2'h0;
   localparam logic [1:0] EDGE_FALL   = 2'h1;
   localparam logic [1:0] EDGE_EITHER = 2'h2;

   localparam logic [1:0] EN_RESET    = 2'h0;
   localparam logic [1:0] ACT_RESET   = 2'h0;

   // One queued message: source code and legacy-format flag.
   typedef struct packed {
      logic [SRC_W-1:0] src;
      logic             legacy;
   } cevn_msg_t;

   // Camera-side event strobes, each a one-cycle pulse.
   typedef struct packed {
      logic       acq_begin;
      logic       acq_finish;
      logic       frame_begin;
      logic       frame_finish;
      logic       frame_trig_accepted;
      logic       frame_trig_rejected;
      logic       image_dropped;
      logic       line_trig_rejected;
      logic       line_trig_postponed;
      logic [3:0] io_pulse;
   } cevn_strobe_t;

endpackage

/* File: cevn_queue.sv */
// Message queue memory for the camera event notifier.
`timescale 1ns/10ps
`default_nettype none

module cevn_queue
   import cevn_pkg::*;
(
   input  wire logic      mclk,
   input  wire logic      sys_rst,
   input  wire logic      wr_en,
   input  wire cevn_msg_t wr_data,
   input  wire logic      rd_en,
   output var  cevn_msg_t rd_data,
   output var  logic      empty,
   output var  logic      full
);

   typedef struct packed {
      cevn_msg_t [QDEPTH-1:0] mem;
      logic [QPTR_W-1:0]      wp;
      logic [QPTR_W-1:0]      rp;
      logic [QCNT_W-1:0]      cnt;
      cevn_msg_t              rd_data;
   } cevn_q_state_t;

   cevn_q_state_t st;
   cevn_q_state_t next_st;
   logic          do_wr;
   logic          do_rd;

   // Read data sits in a register ahead of the reader, refreshed from the head.
   always_comb begin
      next_st = st;
      do_wr   = wr_en && (st.cnt != QCNT_W'(QDEPTH));
      do_rd   = rd_en && (st.cnt != '0);
      if (do_wr) begin
         next_st.mem[st.wp] = wr_data;
         next_st.wp         = st.wp + 3'h1;
      end
      if (do_rd) begin
         next_st.rp = st.rp + 3'h1;
      end
      if (do_wr && !do_rd) begin
         next_st.cnt = st.cnt + 4'h1;
      end else if (do_rd && !do_wr) begin
         next_st.cnt = st.cnt - 4'h1;
      end
      next_st.rd_data = next_st.mem[next_st.rp];
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data = st.rd_data;
   assign empty   = (st.cnt == '0);
   assign full    = (st.cnt == QCNT_W'(QDEPTH));

endmodule

`default_nettype wire

/* File: cevn_asserts.sv */
// Port-level checks for the camera event notifier.
`timescale 1ns/10ps
`default_nettype none
module cevn_asserts
   import cevn_pkg::*;
(
   input wire logic             mclk,
   input wire logic             sys_rst,
   input wire logic [SRC_W-1:0] event_source_select,
   input wire logic             event_send_enable_wr,
   input wire logic [1:0]       event_send_enable_wdata,
   input wire logic             line_edge_activation_wr,
   input wire logic [1:0]       line_edge_activation_wdata,
   input wire logic [1:0]       event_send_enable,
   input wire logic [1:0]       line_edge_activation,
   input wire logic             msg_valid,
   input wire logic [SRC_W-1:0] msg_src,
   input wire logic             msg_legacy,
   input wire logic             msg_ready,
   input wire logic             message_queue_overflow_evt
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // An overflow may override a write, so cycles near one are left out.
   property p_rb(w, wd, rb);
      logic [1:0] d;
      (w && !message_queue_overflow_evt, d = wd) ##1
         (!w && !message_queue_overflow_evt && $stable(event_source_select))[*2] |-> rb == d;
   endproperty
   reset_idle_a: assert property ($fell(sys_rst) |-> !msg_valid && !message_queue_overflow_evt
      && event_send_enable == EN_RESET && line_edge_activation == ACT_RESET)
      else $error("outputs not idle after reset");
   en_readback_a: assert property (p_rb(event_send_enable_wr, event_send_enable_wdata,
      event_send_enable)) else $error("enable readback wrong");
   act_readback_a: assert property (p_rb(line_edge_activation_wr,
      line_edge_activation_wdata, line_edge_activation)) else $error("activation readback wrong");
   msg_hold_a: assert property (msg_valid && !msg_ready |=>
      msg_valid && $stable(msg_src) && $stable(msg_legacy)) else $error("message dropped early");
   ovf_pulse_a: assert property (message_queue_overflow_evt |=> !message_queue_overflow_evt)
      else $error("overflow pulse too long");
   ovf_disable_a: assert property (message_queue_overflow_evt && !event_send_enable_wr
      ##1 !event_send_enable_wr |=> event_send_enable == SEND_OFF)
      else $error("enable survived overflow");
   ovf_report_a: assert property (message_queue_overflow_evt |->
      ##[1:100] (msg_valid && msg_src == SRC_OVERFLOW && !msg_legacy))
      else $error("overflow message missing");
   src_range_a: assert property (msg_valid |-> msg_src <= SRC_OVERFLOW)
      else $error("message source out of range");
   cover property (msg_valid && msg_ready && msg_legacy);
   cover property (message_queue_overflow_evt);
   cover property (msg_valid && !msg_ready ##1 msg_ready);
endmodule
`default_nettype wire

/* File: cevn_host_model.sv */
// Host model that accepts notification messages and logs them.
`timescale 1ns/10ps
`default_nettype none
module cevn_host_model
   import cevn_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic             msg_valid,
   input  wire logic [SRC_W-1:0] msg_src,
   input  wire logic             msg_legacy,
   input  wire logic             hold,
   input  wire logic             fast,
   output var  logic             msg_ready
);
   logic [5:0] got[$];
   // A slow host answers every other cycle; hold stalls it so the queue backs up.
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         msg_ready <= 1'b0;
      end else begin
         if (msg_valid && msg_ready) begin
            got.push_back({msg_legacy, msg_src});
         end
         msg_ready <= !hold && (fast || (msg_valid && !msg_ready));
      end
   end
endmodule
`default_nettype wire

/* File: camera_event_notifier_test.sv */
// Self-checking bench for the camera event notifier.
`timescale 1ns/10ps
`default_nettype none
module camera_event_notifier_test
   import cevn_pkg::*;
;
   logic             mclk = 1'b0;
   logic             sys_rst = 1'b1;
   logic [SRC_W-1:0] sel = 5'h00;
   logic             ewr = 1'b0;
   logic             awr = 1'b0;
   logic [1:0]       wd = 2'h0;
   cevn_strobe_t     stb = '0;
   logic [3:0]       lvl = 4'h0;
   logic [3:0]       outs = 4'h0;
   logic             hold = 1'b0;
   logic             fast = 1'b1;
   logic [1:0]       en_rb;
   logic [1:0]       act_rb;
   logic             vld;
   logic             leg;
   logic             rdy;
   logic             ovf;
   logic [SRC_W-1:0] src;
   int               num_errors = 0;
   int               checks_done = 0;
   int               ovf_seen = 0;
   int               k;
   cevn_notifier cevn_notifier_inst (.mclk(mclk), .sys_rst(sys_rst), .event_source_select(sel),
      .event_send_enable_wr(ewr), .event_send_enable_wdata(wd), .line_edge_activation_wr(awr),
      .line_edge_activation_wdata(wd), .event_send_enable(en_rb), .line_edge_activation(act_rb),
      .strobe(stb), .io_level(lvl), .io_is_output(outs), .msg_valid(vld), .msg_src(src),
      .msg_legacy(leg), .msg_ready(rdy), .message_queue_overflow_evt(ovf));
   cevn_host_model cevn_host_model_inst (.mclk(mclk), .sys_rst(sys_rst), .msg_valid(vld),
      .msg_src(src), .msg_legacy(leg), .hold(hold), .fast(fast), .msg_ready(rdy));
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (ovf === 1'b1) ovf_seen++;
   end
   task automatic stop_test();
      $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [4:0] s, input logic act, input logic [1:0] v);
      @(negedge mclk);
      sel = s;
      ewr = !act;
      awr = act;
      wd = v;
      @(negedge mclk);
      ewr = 1'b0;
      awr = 1'b0;
      repeat (2) @(negedge mclk);
   endtask
   task automatic pulse(input cevn_strobe_t v);
      @(negedge mclk);
      stb = v;
      @(negedge mclk);
      stb = '0;
   endtask
   task automatic expect_msg(input logic [5:0] exp);
      for (int i = 0; i < 60 && cevn_host_model_inst.got.size() == 0; i++) @(negedge mclk);
      if (cevn_host_model_inst.got.size() == 0) begin
         num_errors++;
         $display("[ERR] message expected %h seen none", exp);
         stop_test();
      end else begin
         chk("message", {2'h0, exp}, {2'h0, cevn_host_model_inst.got.pop_front()});
      end
   endtask
   task automatic none();
      repeat (10) @(negedge mclk);
      chk("idle", 8'h00, 8'(cevn_host_model_inst.got.size()));
   endtask
   initial begin
      repeat (4) @(negedge mclk);
      sys_rst = 1'b0;
      @(negedge mclk);
      chk("en_reset", {6'h00, EN_RESET}, {6'h00, en_rb});
      chk("act_reset", {6'h00, ACT_RESET}, {6'h00, act_rb});
      for (k = 0; k < 3; k++) begin
         wr(SRC_ACQ_BEGIN, 1'b0, 2'(k));
         chk("readback", 8'(k), {6'h00, en_rb});
         pulse(13'h1000);
         if (k == 0) none();
         else expect_msg({k == 2, SRC_ACQ_BEGIN});
      end
      // All camera events in one cycle come out in code order.
      for (k = 0; k < 9; k++) wr(5'(k), 1'b0, SEND_ON);
      pulse(13'h1ff0);
      for (k = 0; k < 9; k++)
         expect_msg({1'b0, 5'(k)});
      for (k = 0; k < 4; k++) begin
         wr(5'(9 + k), 1'b1, 2'(k % 3));
         chk("act_readback", 8'(k % 3), {6'h00, act_rb});
         wr(5'(9 + k), 1'b0, SEND_ON);
         lvl[k] = 1'b1;
         // The level must stand across a clock edge before it drops again.
         repeat (2) @(negedge mclk);
         if (k % 3 != 1) expect_msg({1'b0, 5'(9 + k)});
         lvl[k] = 1'b0;
         if (k % 3 != 0) expect_msg({1'b0, 5'(9 + k)});
         none();
         wr(5'(13 + k), 1'b0, SEND_ON);
         pulse(cevn_strobe_t'(13'(1 << k)));
         expect_msg({1'b0, 5'(13 + k)});
      end
      outs[0] = 1'b1;
      lvl[0] = 1'b1;
      none();
      fast = 1'b0;
      hold = 1'b1;
      wr(SRC_ACQ_BEGIN, 1'b0, SEND_ON);
      repeat (12) pulse(13'h1000);
      hold = 1'b0;
      repeat (80) @(negedge mclk);
      chk("ovf_count", 8'h01, 8'(ovf_seen));
      chk("ovf_last", {3'h0, SRC_OVERFLOW}, {2'h0, cevn_host_model_inst.got[$]});
      chk("enable_off", {6'h00, SEND_OFF}, {6'h00, en_rb});
      cevn_host_model_inst.got.delete();
      pulse(13'h1000);
      none();
      wr(SRC_ACQ_BEGIN, 1'b0, SEND_ON);
      pulse(13'h1000);
      expect_msg({1'b0, SRC_ACQ_BEGIN});
      stop_test();
   end
endmodule
bind cevn_notifier cevn_asserts cevn_asserts_inst (.mclk, .sys_rst, .event_source_select,
   .event_send_enable_wr, .event_send_enable_wdata, .line_edge_activation_wr,
   .line_edge_activation_wdata, .event_send_enable, .line_edge_activation, .msg_valid,
   .msg_src, .msg_legacy, .msg_ready, .message_queue_overflow_evt);
`default_nettype wire
